// >>> hw/flash_write_protect_control.v
// flash write sequencer with reset-loaded protection bits, apb slave and interrupt
`timescale 1ns/1ns
`default_nettype none
`include "flash_write_protect_control_regs.vh"

module flash_write_protect_control (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [23:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        bootstrap_mode,
    input  wire        fetch_from_flash,
    output reg         irq,
    output reg         debug_enable,
    output reg         access_protect_active,
    output reg         busy
);

    // ****************************************************************
    // state encoding and constants
    // ****************************************************************
    localparam [4:0] ST_IDLE  = 5'b00001;
    localparam [4:0] ST_PROG  = 5'b00010;
    localparam [4:0] ST_PRE   = 5'b00100;
    localparam [4:0] ST_ERASE = 5'b01000;
    localparam [4:0] ST_DONE  = 5'b10000;
    // the timing count is an integer expression; only the counter's width of it is kept
    localparam integer PROG_N   = `PROG_CYCLES;
    localparam [7:0]   PROG_CNT = PROG_N[7:0];
    localparam [15:0] SEL_MASK = 16'h3900;

    // ****************************************************************
    // storage
    // ****************************************************************
    // flash array, one 32-bit word per entry
    reg  [31:0] mem [0:127];
    // sequencer state, cycle counter and sweep pointer
    reg  [4:0]  st_q;
    reg  [7:0]  cnt_q;
    reg  [6:0]  ptr_q;
    // software-visible registers
    reg  [15:0] ctrl_q;
    reg  [7:0]  sect_q;
    reg  [15:0] d0l_q, d0h_q, d1l_q, d1h_q;
    reg  [15:0] farl_q, farh_q;
    reg         sequence_error_flag_q;
    reg  [1:0]  ist_q, imsk_q;
    // protection words; reset stands in for the delivery values, nothing persists
    reg  [15:0] nvp0_q, pds_q, pen_q;
    // loop index for the array reset
    integer     i;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // one decode used by read mux and write path alike
    function hit;
        input [23:0] a;
        input [21:0] idx;
        begin
            hit = (a[23:2] == idx);
        end
    endfunction

    // byte-lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  sb;
        begin
            merge16 = {sb[1] ? wd[15:8] : old[15:8], sb[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    // operation address as loaded by software, and bus qualifiers
    wire [23:0] far      = {farh_q[7:0], farl_q};
    wire [6:0]  widx     = far[8:2];
    wire        far_main = (far[23:9] == 15'h0000);
    wire        setup    = psel & ~penable;
    wire        acc      = psel & penable & pready;
    wire        wr       = acc & pwrite;
    wire        rd       = acc & ~pwrite;
    // flash window decode: main array and the bootstrap-only test block
    wire        in_main  = (paddr[23:9] == 15'h0000);
    wire        in_test  = (paddr[23:6] == 18'h00008);
    wire        fl_ok    = in_main | (in_test & bootstrap_mode);

    // ****************************************************************
    // protection logic
    // ****************************************************************
    // a disable bit at zero whose enable bit is still one lifts access protection
    wire [15:0] pds_lift  = ~pds_q & pen_q;
    wire        prot_on   = ~nvp0_q[`NVP0_ACCESS_PROTECTION_BIT] & ~(|pds_lift);
    wire        refuse    = prot_on & ~fetch_from_flash;

    // programming order of the disable bits, one gate per bit
    wire [15:0] pds_allow;
    assign pds_allow[0] = ~nvp0_q[`NVP0_DEBUG_PROTECTION_BIT] & ~nvp0_q[`NVP0_ACCESS_PROTECTION_BIT];
    genvar g;
    generate
        for (g = 1; g < 16; g = g + 1) begin : g_allow
            assign pds_allow[g] = ~pen_q[g-1];
        end
    endgenerate
    // a refused bit simply keeps its one, the rest of the word still programs
    wire [15:0] pds_next  = pds_q & ~(~d0l_q & pds_allow);

    // ****************************************************************
    // start checks
    // ****************************************************************
    // the control word as it would look after this write
    wire [15:0] ctrl_w   = merge16(ctrl_q, pwdata, pstrb);
    wire [3:0]  sel_v    = {ctrl_w[`CTRL_WPG], ctrl_w[`CTRL_DOUBLE_WORD_PROGRAM_SELECT], ctrl_w[`CTRL_SER], ctrl_w[`CTRL_SPR]};
    wire        one_sel  = (sel_v == 4'b1000) | (sel_v == 4'b0100) | (sel_v == 4'b0010) | (sel_v == 4'b0001);
    wire        spr_ok   = (far >= `PROT_LO) & (far <= `PROT_HI);
    // test block words never sit in the main array, so a program aimed there fails
    wire        op_ok    = one_sel & ((sel_v[3] & far_main)
                         | (sel_v[2] & far_main & ~far[2])
                         | (sel_v[1] & (sect_q != 8'h00))
                         | (sel_v[0] & spr_ok));
    // a start is honoured only while idle; one sent during an operation is lost
    wire        wr_ctrl  = wr & hit(paddr, `CTRL_IDX) & st_q[0];
    wire        go       = wr_ctrl & ctrl_w[`CTRL_START] & op_ok;
    wire        bad_go   = wr_ctrl & ctrl_w[`CTRL_START] & ~op_ok;
    wire        fin      = st_q[4];
    wire        wr_err   = wr & hit(paddr, `ERR_IDX);
    wire        rd_ist   = rd & hit(paddr, `IST_IDX);

    // ****************************************************************
    // apb slave: answer registered in setup, taken in access
    // ****************************************************************
    // answer computed combinationally, registered on the setup edge
    reg  [31:0] rdata_d;
    reg         err_d;

    // read mux, evaluated during the setup cycle
    always @* begin
        rdata_d = 32'h00000000;
        err_d   = 1'b0;
        if (in_main | in_test) begin
            // direct data writes into flash are never taken, only sequenced ones
            if (pwrite | refuse | ~fl_ok) begin
                err_d = 1'b1;
            end else if (in_main) begin
                rdata_d = mem[paddr[8:2]];
            end else begin
                rdata_d = `WORD_ERASED;
            end
        end else if (hit(paddr, `CTRL_IDX)) begin
            rdata_d = {16'h0000, ctrl_q};
        end else if (hit(paddr, `SECT_IDX)) begin
            rdata_d = {24'h000000, sect_q};
        end else if (hit(paddr, `D0L_IDX)) begin
            rdata_d = {16'h0000, d0l_q};
        end else if (hit(paddr, `D0H_IDX)) begin
            rdata_d = {16'h0000, d0h_q};
        end else if (hit(paddr, `D1L_IDX)) begin
            rdata_d = {16'h0000, d1l_q};
        end else if (hit(paddr, `D1H_IDX)) begin
            rdata_d = {16'h0000, d1h_q};
        end else if (hit(paddr, `FARL_IDX)) begin
            rdata_d = {16'h0000, farl_q};
        end else if (hit(paddr, `FARH_IDX)) begin
            rdata_d = {16'h0000, farh_q};
        end else if (hit(paddr, `ERR_IDX)) begin
            rdata_d = {31'h00000000, sequence_error_flag_q};
        end else if (hit(paddr, `IST_IDX)) begin
            rdata_d = {30'h00000000, ist_q};
        end else if (hit(paddr, `IMSK_IDX)) begin
            rdata_d = {30'h00000000, imsk_q};
        end else if (hit(paddr, `NVP0_IDX)) begin
            rdata_d = {16'h0000, nvp0_q};
        end else if (hit(paddr, `NVPDS_IDX)) begin
            rdata_d = {16'h0000, pds_q};
        end else if (hit(paddr, `NVPEN_IDX)) begin
            rdata_d = {16'h0000, pen_q};
        end else begin
            err_d = 1'b1;
        end
    end

    // pready rises one edge after setup, so every transfer has no wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h00000000 : rdata_d;
            pslverr <= err_d;
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    // address and data stay writable while busy; software keeps them stable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sect_q <= 8'h00;
            d0l_q  <= `DATA_RST;
            d0h_q  <= `DATA_RST;
            d1l_q  <= `DATA_RST;
            d1h_q  <= `DATA_RST;
            farl_q <= 16'h0000;
            farh_q <= 16'h0000;
            imsk_q <= 2'b00;
        end else if (wr) begin
            // strobe lane 0 alone carries the eight sector bits
            if (hit(paddr, `SECT_IDX) & st_q[0] & pstrb[0]) sect_q <= pwdata[7:0];
            if (hit(paddr, `D0L_IDX)) d0l_q <= merge16(d0l_q, pwdata, pstrb);
            if (hit(paddr, `D0H_IDX)) d0h_q <= merge16(d0h_q, pwdata, pstrb);
            if (hit(paddr, `D1L_IDX)) d1l_q <= merge16(d1l_q, pwdata, pstrb);
            if (hit(paddr, `D1H_IDX)) d1h_q <= merge16(d1h_q, pwdata, pstrb);
            if (hit(paddr, `FARL_IDX)) farl_q <= merge16(farl_q, pwdata, pstrb);
            if (hit(paddr, `FARH_IDX)) farh_q <= merge16(farh_q, pwdata, pstrb);
            if (hit(paddr, `IMSK_IDX) & pstrb[0]) imsk_q <= pwdata[1:0];
        end
    end

    // ****************************************************************
    // control register, sequencer and flash array
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= ST_IDLE;
            cnt_q  <= 8'h00;
            ptr_q  <= 7'h00;
            ctrl_q <= `CTRL_RST;
            nvp0_q <= `NVP0_RST;
            pds_q  <= `NVPDS_RST;
            pen_q  <= `NVPEN_RST;
            for (i = 0; i < 128; i = i + 1) begin
                mem[i] <= `WORD_ERASED;
            end
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (wr_ctrl) begin
                        // a refused start leaves the selects but drops the start bit
                        ctrl_q <= ctrl_w & (SEL_MASK | 16'h4000 | (op_ok ? 16'h8000 : 16'h0000));
                    end
                    // counters rest at zero so each operation starts a clean count
                    cnt_q <= 8'h00;
                    ptr_q <= 7'h00;
                    if (go) begin
                        st_q <= ctrl_w[`CTRL_SER] ? ST_PRE : ST_PROG;
                    end
                end
                ST_PROG: begin
                    // the array changes only on the last counted cycle
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == PROG_CNT - 8'h01) begin
                        st_q <= ST_DONE;
                        if (ctrl_q[`CTRL_WPG]) begin
                            mem[widx] <= mem[widx] & {d0h_q, d0l_q};
                        end
                        if (ctrl_q[`CTRL_DOUBLE_WORD_PROGRAM_SELECT]) begin
                            mem[widx] <= mem[widx] & {d0h_q, d0l_q};
                            mem[{widx[6:1], 1'b1}] <= mem[{widx[6:1], 1'b1}] & {d1h_q, d1l_q};
                        end
                        // only the low half of data pair 0 reaches a protection word
                        if (ctrl_q[`CTRL_SPR]) begin
                            if ({far[23:2], 2'b00} == `NVP0_ADDR) begin
                                nvp0_q[1:0] <= nvp0_q[1:0] & d0l_q[1:0];
                            end
                            if ({far[23:2], 2'b00} == `NVPDS_ADDR) begin
                                pds_q <= pds_next;
                            end
                            if ({far[23:2], 2'b00} == `NVPEN_ADDR) begin
                                pen_q <= pen_q & d0l_q;
                            end
                        end
                    end
                end
                ST_PRE: begin
                    // zero the chosen sectors first so every cell erases evenly
                    if (sect_q[ptr_q[6:4]]) mem[ptr_q] <= `WORD_ZERO;
                    ptr_q <= ptr_q + 7'h01;
                    if (ptr_q == 7'h7f) st_q <= ST_ERASE;
                end
                ST_ERASE: begin
                    // second sweep brings the chosen sectors back to the erased pattern
                    if (sect_q[ptr_q[6:4]]) mem[ptr_q] <= `WORD_ERASED;
                    ptr_q <= ptr_q + 7'h01;
                    if (ptr_q == 7'h7f) st_q <= ST_DONE;
                end
                ST_DONE: begin
                    // selects and start drop together at the end of any operation
                    ctrl_q <= ctrl_q & 16'h4000;
                    st_q   <= ST_IDLE;
                end
                default: begin
                    // an illegal state falls back to idle
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // error flag, interrupt and status outputs
    // ****************************************************************
    // events win over a clearing write or read in the same cycle
    wire       sequence_error_flag_d = bad_go | (wr_err ? pwdata[0] : sequence_error_flag_q);
    // status bit 0 marks completion, bit 1 a refused start
    wire [1:0] ev      = {bad_go, fin};
    wire [1:0] ist_d   = ev | (rd_ist ? 2'b00 : ist_q);

    // every output leaves a flip-flop, so the pins never see decode glitches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sequence_error_flag_q               <= 1'b0;
            ist_q                 <= 2'b00;
            irq                   <= 1'b0;
            debug_enable          <= 1'b1;
            access_protect_active <= 1'b0;
            busy                  <= 1'b0;
        end else begin
            sequence_error_flag_q               <= sequence_error_flag_d;
            ist_q                 <= ist_d;
            irq                   <= |(ist_d & imsk_q);
            debug_enable          <= nvp0_q[`NVP0_DEBUG_PROTECTION_BIT];
            access_protect_active <= prot_on;
            busy                  <= ~st_q[0];
        end
    end

endmodule // flash_write_protect_control
`default_nettype wire

// >>> hw/flash_write_protect_control_regs.vh
// register indexes, field positions, reset values and timing counts of the flash write/protect control
//
// Contract
// - set-protection: select, load address/data0, start
// - set-protection address outside range flags sequence error
// - set-protection select clears when operation ends
// - sector erase sets chosen sectors to ones
// - erase pre-programs chosen sectors to zeros first
// - sector-erase select clears when erase ends
// - double-word: even address, data0 even, data1 odd
// - double-word select clears when program ends
// - programming only turns ones into zeros
// - word program: select, load address/data0, start
// - word-program select clears when program ends
// - test block unwritable, visible only in bootstrap
// - access protection refuses non-flash-fetched data access
// - debug protection zero disables debug and test; here it drops only debug_enable, the test block stays readable in bootstrap
// - disable bit zero with enable one cancels protection
// - lowest disable bit needs debug+access programmed first
// - disable bit x needs enable bit x-1 programmed
`ifndef FLASH_WRITE_PROTECT_CONTROL_REGS_VH
`define FLASH_WRITE_PROTECT_CONTROL_REGS_VH

// ****************************************************************
// register indexes (byte address is four times the index)
// ****************************************************************
`define CTRL_IDX   22'h080002
`define SECT_IDX   22'h080004
`define D0L_IDX    22'h080008
`define D0H_IDX    22'h08000a
`define D1L_IDX    22'h08000c
`define D1H_IDX    22'h08000e
`define FARL_IDX   22'h080010
`define FARH_IDX   22'h080012
`define ERR_IDX    22'h080014
`define IST_IDX    22'h080020
`define IMSK_IDX   22'h080022
`define NVPEN_IDX  22'h08dfb0
`define NVP0_IDX   22'h08dfb8
`define NVPDS_IDX  22'h08dfbc

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_START 15
`define CTRL_OPERATION_SUSPEND_BIT  14
`define CTRL_WPG   13
`define CTRL_DOUBLE_WORD_PROGRAM_SELECT  12
`define CTRL_SER   11
`define CTRL_SPR   8
`define NVP0_ACCESS_PROTECTION_BIT  0
`define NVP0_DEBUG_PROTECTION_BIT  1
`define IST_DONE   0
`define IST_SEQUENCE_ERROR_FLAG  1

// ****************************************************************
// reset values, flash addresses and data patterns
// ****************************************************************
`define CTRL_RST   16'h0000
`define DATA_RST   16'hffff
`define NVP0_RST   16'hacff
`define NVPDS_RST  16'hffff
`define NVPEN_RST  16'hffff
`define NVPEN_ADDR 24'h08dfb0
`define NVP0_ADDR  24'h08dfb8
`define NVPDS_ADDR 24'h08dfbc
`define PROT_LO    24'h08dfb0
`define PROT_HI    24'h08dfbf
`define WORD_ERASED 32'hffffffff
`define WORD_ZERO  32'h00000000

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 20
`define PROG_TIME_NS  100
`define PROG_CYCLES   ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> verification/flash_write_protect_control_sva.sv
// assertion checker for the flash write/protect control bus and protection outputs
`timescale 1ns/1ns
`default_nettype none
module flash_write_protect_control_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [23:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        bootstrap_mode,
    input wire logic        fetch_from_flash,
    input wire logic        irq,
    input wire logic        debug_enable,
    input wire logic        access_protect_active,
    input wire logic        busy
);
    // ****************************************************************
    // bus and protection properties
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a transfer completing in this cycle
    wire logic acc = psel && penable && pready;

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready stood two cycles");
    a_testblk_hidden: assert property (acc && !pwrite && paddr >= 24'h200 && paddr < 24'h240
        && !bootstrap_mode |-> pslverr) else $error("test block read outside bootstrap");
    a_flash_wr_refused: assert property (acc && pwrite && paddr < 24'h240 |-> pslverr)
        else $error("direct flash write accepted");
    a_protected_read: assert property (acc && !pwrite && paddr < 24'h200
        && access_protect_active && !fetch_from_flash |-> pslverr) else $error("protected read accepted");
    a_permitted_read: assert property (acc && !pwrite && paddr < 24'h200 && fetch_from_flash
        |-> !pslverr) else $error("read from flash fetch refused");
    a_op_bounded: assert property ($rose(busy) |-> ##[1:400] !busy)
        else $error("operation never finished");
    a_debug_sticky: assert property (!$rose(debug_enable))
        else $error("debug protection returned to one");
    a_debug_by_op: assert property ($fell(debug_enable) |-> busy || $past(busy) || $past(busy, 2))
        else $error("debug disabled without operation");
    a_protect_by_op: assert property ($changed(access_protect_active)
        |-> busy || $past(busy) || $past(busy, 2)) else $error("protection changed without operation");
endmodule // flash_write_protect_control_sva

bind flash_write_protect_control flash_write_protect_control_sva u_flash_write_protect_control_sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .bootstrap_mode, .fetch_from_flash, .irq, .debug_enable, .access_protect_active, .busy);
`default_nettype wire

// >>> verification/flash_write_protect_control_tb_top.sv
// self-checking bench for the flash write/protect control block
`timescale 1ns/1ns
`default_nettype none
`include "flash_write_protect_control_regs.vh"
module flash_write_protect_control_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [23:0] paddr = 24'h000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'hf;
    logic        bootstrap_mode = 1'b0;
    logic        fetch_from_flash = 1'b0;
    wire logic [31:0] prdata;
    wire logic   pready, pslverr, irq, debug_enable, access_protect_active, busy;
    int          n_fail = 0;
    int          n_compared = 0;
    logic [33:0] exq [$];
    logic [33:0] e;
    logic [31:0] seed = 32'd38951;
    logic [31:0] r1, r2, r3, r4, r5;

    flash_write_protect_control u_flash_write_protect_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bootstrap_mode(bootstrap_mode), .fetch_from_flash(fetch_from_flash), .irq(irq),
        .debug_enable(debug_enable), .access_protect_active(access_protect_active), .busy(busy));

    always #10 pclk = ~pclk;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic timeout();
        n_fail++;
        $display("CHECK FAILED wait expected done seen timeout");
        end_of_test();
    endtask

    // monitor: each completed transfer is matched against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exq.size() > 0) begin
            e = exq.pop_front();
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (e[33]) chk("prdata", e[31:0], prdata);
        end
    end

    // request stays up until idle releases it, so back-to-back transfers never retoggle psel
    task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d, input logic ee,
                       input logic [31:0] ed);
        int n = 0;
        exq.push_back({~w & ~ee, ee, ed});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) timeout();
    endtask

    task automatic wr(input logic [21:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'b00}, d, 1'b0, 32'h0);
    endtask

    task automatic rd(input logic [21:0] i, input logic [31:0] ex);
        apb(1'b0, {i, 2'b00}, 32'h0, 1'b0, ex);
    endtask

    task automatic idle(input int k);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (k) @(posedge pclk);
    endtask

    task automatic wait_idle(input logic eb);
        int n = 0;
        idle(3);
        chk("busy", {31'h0, eb}, {31'h0, busy});
        while (busy !== 1'b0 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        if (n == 500) timeout();
    endtask

    // load address and data, start, wait, then read back the control word
    task automatic op(input logic [23:0] far, input logic [31:0] d0, input logic [31:0] d1,
                      input logic [15:0] c, input logic [15:0] ec);
        wr(`FARL_IDX, {16'h0, far[15:0]});
        wr(`FARH_IDX, {24'h0, far[23:16]});
        wr(`D0L_IDX, {16'h0, d0[15:0]});
        wr(`D0H_IDX, {16'h0, d0[31:16]});
        wr(`D1L_IDX, {16'h0, d1[15:0]});
        wr(`D1H_IDX, {16'h0, d1[31:16]});
        wr(`CTRL_IDX, {16'h0, c});
        wait_idle(ec == 16'h0000);
        rd(`CTRL_IDX, {16'h0, ec});
    endtask

    // level outputs are sampled mid-cycle, away from the edge that updates them
    task automatic pins(input logic xd, input logic xa, input logic xi);
        idle(1);
        @(negedge pclk);
        chk("debug_enable", {31'h0, xd}, {31'h0, debug_enable});
        chk("access_protect_active", {31'h0, xa}, {31'h0, access_protect_active});
        chk("irq", {31'h0, xi}, {31'h0, irq});
        @(posedge pclk);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        r1 = xs();
        r2 = xs();
        r3 = xs();
        r4 = xs();
        r5 = xs();
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        pins(1'b1, 1'b0, 1'b0);
        rd(`CTRL_IDX, 32'h0000);
        rd(`D0H_IDX, 32'hffff);
        rd(`D1L_IDX, 32'hffff);
        rd(`D1H_IDX, 32'hffff);
        rd(`NVP0_IDX, 32'hacff);
        rd(`NVPDS_IDX, 32'hffff);
        apb(1'b0, {22'h080030, 2'b00}, 32'h0, 1'b1, 32'h0);
        wr(`IMSK_IDX, 32'h1);
        op(24'h000040, r1, 32'h0, 16'ha000, 16'h0000);
        apb(1'b0, 24'h000040, 32'h0, 1'b0, r1);
        pins(1'b1, 1'b0, 1'b1);
        rd(`IST_IDX, 32'h1);
        pins(1'b1, 1'b0, 1'b0);
        op(24'h000040, r2, 32'h0, 16'ha000, 16'h0000);
        apb(1'b0, 24'h000040, 32'h0, 1'b0, r1 & r2);
        op(24'h000000, r3, 32'h0, 16'ha000, 16'h0000);
        op(24'h000080, r4, r5, 16'h9000, 16'h0000);
        apb(1'b0, 24'h000080, 32'h0, 1'b0, r4);
        apb(1'b0, 24'h000084, 32'h0, 1'b0, r5);
        op(24'h000084, r4, r5, 16'h9000, 16'h1000);
        rd(`ERR_IDX, 32'h1);
        wr(`ERR_IDX, 32'h0);
        wr(`SECT_IDX, 32'h01);
        op(24'h000000, r1, r2, 16'h8800, 16'h0000);
        apb(1'b0, 24'h000000, 32'h0, 1'b0, 32'hffffffff);
        apb(1'b0, 24'h00003c, 32'h0, 1'b0, 32'hffffffff);
        apb(1'b0, 24'h000040, 32'h0, 1'b0, r1 & r2);
        apb(1'b0, 24'h200, 32'h0, 1'b1, 32'h0);
        bootstrap_mode <= 1'b1;
        apb(1'b0, 24'h200, 32'h0, 1'b0, 32'hffffffff);
        apb(1'b1, 24'h200, r3, 1'b1, 32'h0);
        op(24'h08dfc0, r1, r2, 16'h8100, 16'h0100);
        rd(`ERR_IDX, 32'h1);
        rd(`IST_IDX, 32'h3);
        op(`NVPDS_ADDR, 32'hfffe, 32'h0, 16'h8100, 16'h0000);
        rd(`NVPDS_IDX, 32'hffff);
        op(`NVP0_ADDR, 32'hfffc, 32'h0, 16'h8100, 16'h0000);
        rd(`NVP0_IDX, 32'hacfc);
        pins(1'b0, 1'b1, 1'b1);
        apb(1'b0, 24'h000040, 32'h0, 1'b1, 32'h0);
        fetch_from_flash <= 1'b1;
        apb(1'b0, 24'h000040, 32'h0, 1'b0, r1 & r2);
        op(`NVPDS_ADDR, 32'hfffd, 32'h0, 16'h8100, 16'h0000);
        rd(`NVPDS_IDX, 32'hffff);
        op(`NVPDS_ADDR, 32'hfffe, 32'h0, 16'h8100, 16'h0000);
        rd(`NVPDS_IDX, 32'hfffe);
        pins(1'b0, 1'b0, 1'b1);
        op(`NVPEN_ADDR, 32'hfffe, 32'h0, 16'h8100, 16'h0000);
        rd(`NVPEN_IDX, 32'hfffe);
        pins(1'b0, 1'b1, 1'b1);
        op(`NVPDS_ADDR, 32'hfffc, 32'h0, 16'h8100, 16'h0000);
        rd(`NVPDS_IDX, 32'hfffc);
        idle(2);
        end_of_test();
    end
endmodule // flash_write_protect_control_tb_top
`default_nettype wire
